// ### uart_multiproc_receive_status_tb.sv
// Self-checking bench: station and device joined over the serial link
`timescale 1ns/1ns
`include "ump_defines.svh"
module uart_multiproc_receive_status_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct packed {
    logic multiproc_mode_bit;
    logic nine;
    logic u2x;
    logic [8:0] word;
    logic rx_complete_flag;
    logic fe;
    logic [7:0] data;
  } ump_row_t;
  localparam int FRAME = 176;
  localparam logic [5:0] I_DIV = `UMP_IDX_DIVISOR;
  localparam logic [5:0] I_CTL = `UMP_IDX_CONTROL;
  localparam logic [5:0] I_ST = `UMP_IDX_STATUS_A;
  localparam logic [5:0] I_DAT = `UMP_IDX_DATA;
  ump_row_t rows [7];
  ump_row_t r;
  logic clk_i, rst_i, ce, cyc, stb, we, ack, txc_ack, rxc_irq, txc_irq;
  logic tx_valid, tx_ready, rx_valid, rx_err;
  logic [7:0] adr, q;
  logic [31:0] wdat, rdat;
  logic [8:0] tx_data, rx_data;
  logic [5:0] chk_idx [5] = '{I_DIV, I_CTL, I_ST, I_DAT, 6'h3f};
  logic [7:0] chk_val [5] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
  int fails, compares, n;
  ump_link_if link_bus ();
  ump_dev u_ump_dev (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .txc_irq_ack_i(txc_ack), .rxc_irq_o(rxc_irq), .txc_irq_o(txc_irq), .link(link_bus.dev)
  );
  ump_station #(.TICK_DIV(8'h00), .DEPTH(8)) u_ump_station (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .tx_data_i(tx_data), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_frame_err_o(rx_err), .link(link_bus.st)
  );
  ump_link_props #(.TICK_DIV(8'h00)) u_ump_link_props (
    .clk_i(clk_i), .rst_i(rst_i), .st_line(link_bus.st_line), .dev_line(link_bus.dev_line)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic [5:0] idx, input logic w, input logic [7:0] d, output logic [7:0] rv);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 100);
    rv = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk("ack", 32'(k < 100), 32'h1);
  endtask : wb
  task automatic push(input logic [8:0] w);
    int k;
    k = 0;
    @(posedge clk_i);
    tx_valid <= 1'b1;
    tx_data <= w;
    do begin
      @(posedge clk_i);
      k++;
    end while (tx_ready !== 1'b1 && k < 50);
    tx_valid <= 1'b0;
  endtask : push
  task automatic wait_hi(input logic use_txc);
    int k;
    k = 0;
    while ((use_txc ? txc_irq : rx_valid) !== 1'b1 && k < 2 * FRAME) begin
      @(posedge clk_i);
      k++;
    end
    chk("wait", 32'(k < 2 * FRAME), 32'h1);
  endtask : wait_hi
  task automatic test_done();
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    test_done();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_i, cyc, stb, we, txc_ack, tx_valid} = 6'h20;
    ce = 1'b1;
    adr = 8'h00;
    wdat = 32'h0;
    tx_data = 9'h000;
    fails = 0;
    compares = 0;
    rows[0] = '{1'b1, 1'b0, 1'b0, 9'h1a5, 1'b1, 1'b0, 8'ha5};
    rows[1] = '{1'b0, 1'b0, 1'b0, 9'h05a, 1'b1, 1'b1, 8'h5a};
    rows[2] = '{1'b1, 1'b0, 1'b0, 9'h03c, 1'b0, 1'b1, 8'h5a};
    rows[3] = '{1'b0, 1'b1, 1'b0, 9'h0c3, 1'b1, 1'b0, 8'hc3};
    rows[4] = '{1'b1, 1'b1, 1'b0, 9'h1ff, 1'b1, 1'b0, 8'hff};
    rows[5] = '{1'b1, 1'b1, 1'b0, 9'h011, 1'b0, 1'b0, 8'hff};
    rows[6] = '{1'b0, 1'b0, 1'b1, 9'h1c7, 1'b1, 1'b0, 8'hc7};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      r = rows[i];
      wb(I_DIV, 1'b1, {7'h00, r.u2x}, q);
      wb(I_ST, 1'b1, {6'h00, r.u2x, r.multiproc_mode_bit}, q);
      wb(I_CTL, 1'b1, {1'b1, 4'h0, r.nine, 2'b00}, q);
      push(r.word);
      repeat (FRAME + 32) @(posedge clk_i);
      wb(I_ST, 1'b0, 8'h00, q);
      chk("rx_done", 32'(q[`UMP_B_RXC]), 32'(r.rx_complete_flag));
      chk("frame_err", 32'(q[4]), 32'(r.fe));
      chk("rxc_irq", 32'(rxc_irq), 32'(r.rx_complete_flag));
      wb(I_CTL, 1'b0, 8'h00, q);
      if (r.nine && r.rx_complete_flag) chk("rx_ninth", 32'(q[1]), 32'(r.word[8]));
      wb(I_DAT, 1'b0, 8'h00, q);
      chk("rx_data", 32'(q), 32'(r.data));
      wb(I_ST, 1'b0, 8'h00, q);
      chk("rx_clear", 32'({q[`UMP_B_RXC], rxc_irq}), 32'h0);
      wb(I_DAT, 1'b1, r.data, q);
      wait_hi(1'b0);
      chk("echo", 32'({rx_err, rx_data}), 32'({1'b0, ~r.nine, r.data}));
      wait_hi(1'b1);
      wb(I_ST, 1'b0, 8'h00, q);
      chk("tx_done", 32'({q[`UMP_B_TXC], q[5]}), 32'h3);
      if (i % 2 == 0) begin
        wb(I_ST, 1'b1, {2'b01, 4'h0, r.u2x, r.multiproc_mode_bit}, q);
      end else begin
        @(posedge clk_i);
        txc_ack <= 1'b1;
        @(posedge clk_i);
        txc_ack <= 1'b0;
      end
      @(posedge clk_i);
      chk("tx_clear", 32'(txc_irq), 32'h0);
    end
    wb(I_DIV, 1'b1, 8'h00, q);
    wb(I_ST, 1'b1, 8'h01, q);
    n = 0;
    @(posedge clk_i);
    tx_valid <= 1'b1;
    tx_data <= 9'h055;
    do begin
      @(posedge clk_i);
      if (tx_ready === 1'b1) n++;
    end while (tx_ready === 1'b1 && n < 12);
    tx_valid <= 1'b0;
    chk("fill", 32'(n >= 8 && n <= 9), 32'h1);
    repeat (11 * FRAME) @(posedge clk_i);
    chk("drain", 32'({tx_ready, link_bus.st_line}), 32'h3);
    wb(I_DAT, 1'b1, 8'h0f, q);
    push(9'h1aa);
    repeat (60) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("idle", 32'({link_bus.st_line, link_bus.dev_line, tx_ready}), 32'h7);
    wb(6'h3f, 1'b1, 8'hff, q);
    foreach (chk_idx[j]) begin
      wb(chk_idx[j], 1'b0, 8'h00, q);
      chk("reset_val", 32'(q), 32'(chk_val[j]));
    end
    @(posedge clk_i);
    ce <= 1'b0;
    cyc <= 1'b1;
    stb <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("frozen", 32'(ack), 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
    ce <= 1'b1;
    test_done();
  end
endmodule : uart_multiproc_receive_status_tb

// ### ump_defines.svh
// Register indices, field positions, reset values and bit timing of the serial port
`ifndef UMP_DEFINES_SVH
`define UMP_DEFINES_SVH
// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define UMP_IDX_DIVISOR 6'h09
`define UMP_IDX_CONTROL 6'h0a
`define UMP_IDX_STATUS_A 6'h0b
`define UMP_IDX_DATA 6'h0c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define UMP_B_RXC 7
`define UMP_B_TXC 6
`define UMP_B_U2X 1
`define UMP_B_MULTIPROC_MODE_BIT 0
`define UMP_B_RX_COMPLETE_IRQ_ENABLE 7
`define UMP_B_CHAR9 2
`define UMP_B_TX9 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define UMP_RST_BYTE 8'h00
`define UMP_RST_DIV 8'h00
// ----------------------------------------
// Bit timing
// ----------------------------------------
`define UMP_OVS_NORM 5'h10
`define UMP_OVS_FAST 5'h08
`define UMP_NB8 4'h9
`define UMP_NB9 4'ha
`define UMP_IDLE_FRAME 11'h7ff
`endif

// ### ump_dev.sv
// Device end: serial port with multi-processor addressing and Wishbone registers
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`include "ump_defines.svh"
module ump_dev (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt requests
  input wire logic txc_irq_ack_i,
  output logic rxc_irq_o,
  output logic txc_irq_o,
  // Serial link
  ump_link_if.dev link
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic ack_r;
  logic [31:0] dat_r;
  logic [7:0] baud_divisor_r;
  logic rx_complete_irq_enable_r;
  logic char9_r;
  logic tx_ninth_r;
  logic rx_ninth_r;
  logic rx_complete_flag_r;
  logic tx_complete_flag_r;
  logic frame_error_flag_r;
  logic overrun_r;
  logic double_speed_bit_r;
  logic multiproc_mode_bit_r;
  logic [7:0] tdr_r;
  logic tdr_full_r;
  logic [7:0] rdr_r;
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic ump_hit(input logic [5:0] idx, input logic [5:0] want);
    ump_hit = (idx == want);
  endfunction : ump_hit
  wire [5:0] idx = wb_adr_i[7:2];
  wire req = wb_cyc_i & wb_stb_i & ~ack_r & ce_i;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire rd = req & ~wb_we_i;
  wire wr_div = wr & ump_hit(idx, `UMP_IDX_DIVISOR);
  wire wr_ctl = wr & ump_hit(idx, `UMP_IDX_CONTROL);
  wire wr_sta = wr & ump_hit(idx, `UMP_IDX_STATUS_A);
  wire wr_dat = wr & ump_hit(idx, `UMP_IDX_DATA);
  wire rd_dat = rd & ump_hit(idx, `UMP_IDX_DATA);
  wire data_reg_empty_flag = ~tdr_full_r;
  wire [7:0] sta_val = {rx_complete_flag_r, tx_complete_flag_r, data_reg_empty_flag, frame_error_flag_r,
                        overrun_r, 1'b0, double_speed_bit_r, multiproc_mode_bit_r};
  wire [7:0] ctl_val = {rx_complete_irq_enable_r, 4'h0, char9_r, rx_ninth_r, tx_ninth_r};
  wire [7:0] rd_mux = ump_hit(idx, `UMP_IDX_DIVISOR) ? baud_divisor_r :
                      ump_hit(idx, `UMP_IDX_CONTROL) ? ctl_val :
                      ump_hit(idx, `UMP_IDX_STATUS_A) ? sta_val :
                      ump_hit(idx, `UMP_IDX_DATA) ? rdr_r : `UMP_RST_BYTE;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign rxc_irq_o = rx_complete_flag_r & rx_complete_irq_enable_r;
  assign txc_irq_o = tx_complete_flag_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else if (ce_i) begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      if (rd) begin
        dat_r <= {24'h0, rd_mux};
      end
    end
  end
  // ----------------------------------------
  // Baud tick
  // ----------------------------------------
  logic [7:0] bcnt_r;
  wire tick = (bcnt_r == baud_divisor_r);
  wire [4:0] ovs = double_speed_bit_r ? `UMP_OVS_FAST : `UMP_OVS_NORM;
  wire [4:0] half = {1'b0, ovs[4:1]};
  wire [3:0] nb = char9_r ? `UMP_NB9 : `UMP_NB8;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcnt_r <= '0;
    end else if (ce_i) begin
      bcnt_r <= tick ? 8'h00 : bcnt_r + 8'h01;
    end
  end
  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  ump_pkg::ump_tx_state_t tx_st_r;
  logic [10:0] tsh_r;
  logic [3:0] tcnt_r;
  logic [4:0] tsub_r;
  wire [9:0] tframe = char9_r ? {1'b1, tx_ninth_r, tdr_r} : {2'b11, tdr_r};
  wire tx_load = (tx_st_r == ump_pkg::UMP_TX_IDLE) & tdr_full_r;
  wire tbit_end = (tx_st_r == ump_pkg::UMP_TX_SEND) & tick & (tsub_r == ovs - 5'h01);
  wire tx_done = tbit_end & (tcnt_r == 4'h0) & ~tdr_full_r & ~wr_dat;
  assign link.dev_line = tsh_r[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_r <= ump_pkg::UMP_TX_IDLE;
      tsh_r <= `UMP_IDLE_FRAME;
      tcnt_r <= '0;
      tsub_r <= '0;
    end else if (ce_i) begin
      case (tx_st_r)
        ump_pkg::UMP_TX_IDLE: begin
          if (tx_load) begin
            tsh_r <= {tframe, 1'b0};
            tcnt_r <= nb;
            tsub_r <= '0;
            tx_st_r <= ump_pkg::UMP_TX_SEND;
          end
        end
        ump_pkg::UMP_TX_SEND: begin
          if (tbit_end) begin
            tsub_r <= '0;
            tsh_r <= {1'b1, tsh_r[10:1]};
            if (tcnt_r == 4'h0) begin
              tx_st_r <= ump_pkg::UMP_TX_IDLE;
            end else begin
              tcnt_r <= tcnt_r - 4'h1;
            end
          end else if (tick) begin
            tsub_r <= tsub_r + 5'h01;
          end
        end
        default: tx_st_r <= ump_pkg::UMP_TX_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  ump_pkg::ump_rx_state_t rx_st_r;
  logic [9:0] rsh_r;
  logic [3:0] rcnt_r;
  logic [4:0] rsub_r;
  logic rx_done_r;
  logic rx_armed_r;
  wire rline = link.st_line;
  wire rbit_end = (rx_st_r == ump_pkg::UMP_RX_RECV) & tick & (rsub_r == ovs - 5'h01);
  wire mark = rsh_r[8];
  wire stop_bit = char9_r ? rsh_r[9] : rsh_r[8];
  wire accept = rx_done_r & (~multiproc_mode_bit_r | mark);
  wire rx_set = accept & (~rx_complete_flag_r | rd_dat);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_r <= ump_pkg::UMP_RX_IDLE;
      rsh_r <= '0;
      rcnt_r <= '0;
      rsub_r <= '0;
      rx_done_r <= 1'b0;
      rx_armed_r <= 1'b0;
    end else if (ce_i) begin
      rx_done_r <= 1'b0;
      case (rx_st_r)
        ump_pkg::UMP_RX_IDLE: begin
          // Start needs a high line first
          if (tick & ~rline & rx_armed_r) begin
            rsub_r <= 5'h01;
            rx_armed_r <= 1'b0;
            rx_st_r <= ump_pkg::UMP_RX_HUNT;
          end else if (tick & rline) begin
            rx_armed_r <= 1'b1;
          end
        end
        ump_pkg::UMP_RX_HUNT: begin
          if (tick) begin
            if (rsub_r == half - 5'h01) begin
              rsub_r <= '0;
              rcnt_r <= '0;
              rx_st_r <= rline ? ump_pkg::UMP_RX_IDLE : ump_pkg::UMP_RX_RECV;
            end else begin
              rsub_r <= rsub_r + 5'h01;
            end
          end
        end
        ump_pkg::UMP_RX_RECV: begin
          if (rbit_end) begin
            rsub_r <= '0;
            rsh_r[rcnt_r] <= rline;
            if (rcnt_r == nb - 4'h1) begin
              rx_done_r <= 1'b1;
              rx_st_r <= ump_pkg::UMP_RX_IDLE;
            end else begin
              rcnt_r <= rcnt_r + 4'h1;
            end
          end else if (tick) begin
            rsub_r <= rsub_r + 5'h01;
          end
        end
        default: rx_st_r <= ump_pkg::UMP_RX_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Control and status
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_divisor_r <= `UMP_RST_DIV;
      rx_complete_irq_enable_r <= 1'b0;
      char9_r <= 1'b0;
      tx_ninth_r <= 1'b0;
      rx_ninth_r <= 1'b0;
      rx_complete_flag_r <= 1'b0;
      tx_complete_flag_r <= 1'b0;
      frame_error_flag_r <= 1'b0;
      overrun_r <= 1'b0;
      double_speed_bit_r <= 1'b0;
      multiproc_mode_bit_r <= 1'b0;
      tdr_r <= `UMP_RST_BYTE;
      tdr_full_r <= 1'b0;
      rdr_r <= `UMP_RST_BYTE;
    end else if (ce_i) begin
      if (wr_div) begin
        baud_divisor_r <= wb_dat_i[7:0];
      end
      if (wr_ctl) begin
        rx_complete_irq_enable_r <= wb_dat_i[`UMP_B_RX_COMPLETE_IRQ_ENABLE];
        char9_r <= wb_dat_i[`UMP_B_CHAR9];
        tx_ninth_r <= wb_dat_i[`UMP_B_TX9];
      end
      if (wr_sta) begin
        double_speed_bit_r <= wb_dat_i[`UMP_B_U2X];
        multiproc_mode_bit_r <= wb_dat_i[`UMP_B_MULTIPROC_MODE_BIT];
      end
      if (wr_dat) begin
        tdr_r <= wb_dat_i[7:0];
      end
      tdr_full_r <= wr_dat | (tdr_full_r & ~tx_load);
      tx_complete_flag_r <= tx_done | (tx_complete_flag_r & ~txc_irq_ack_i & ~(wr_sta & wb_dat_i[`UMP_B_TXC]));
      rx_complete_flag_r <= rx_set | (rx_complete_flag_r & ~rd_dat);
      overrun_r <= (accept & rx_complete_flag_r & ~rd_dat) | (overrun_r & ~rd_dat);
      if (rx_set) begin
        rdr_r <= rsh_r[7:0];
        rx_ninth_r <= mark;
        frame_error_flag_r <= ~stop_bit;
      end
    end
  end
endmodule : ump_dev

// ### ump_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ns
module ump_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] cnt_r;
  wire push = in_valid_i & in_ready_o & ce_i;
  wire pop = out_valid_o & out_ready_i & ce_i;
  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem[rptr_r];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr_r] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ump_fifo

// ### ump_link_if.sv
// Serial line pair between the station and the device
`timescale 1ns/1ns
interface ump_link_if;
  logic st_line;
  logic dev_line;
  modport dev (input st_line, output dev_line);
  modport st (input dev_line, output st_line);
endinterface : ump_link_if

// ### ump_link_props.sv
// Assertions on the two serial lines between station and device
`timescale 1ns/1ns
module ump_link_props #(
  parameter logic [7:0] TICK_DIV = 8'h00
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial lines
  input wire logic st_line,
  input wire logic dev_line
);
  // ----------------------------------------
  // Frame position and low-run trackers
  // ----------------------------------------
  localparam int BIT = 16 * (int'(TICK_DIV) + 1);
  logic [11:0] st_pos_r;
  logic [11:0] dev_pos_r;
  logic [11:0] st_low_r;
  logic [11:0] dev_low_r;
  wire logic st_end = st_pos_r == 12'(11 * BIT - 1);
  wire logic dev_end = dev_pos_r == 12'(10 * BIT - 1);
  wire logic [11:0] st_pos_nxt = (st_pos_r != 12'h000) ? (st_end ? 12'h000 : st_pos_r + 12'h001) : {11'h000, ~st_line};
  wire logic [11:0] dev_pos_nxt = (dev_pos_r != 12'h000) ? (dev_end ? 12'h000 : dev_pos_r + 12'h001) : {11'h000, ~dev_line};
  wire logic [11:0] st_low_nxt = st_line ? 12'h000 : st_low_r + 12'h001;
  wire logic [11:0] dev_low_nxt = dev_line ? 12'h000 : dev_low_r + 12'h001;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_pos_r <= 12'h000;
      dev_pos_r <= 12'h000;
      st_low_r <= 12'h000;
      dev_low_r <= 12'h000;
    end else begin
      st_pos_r <= st_pos_nxt;
      dev_pos_r <= dev_pos_nxt;
      st_low_r <= st_low_nxt;
      dev_low_r <= dev_low_nxt;
    end
  end
  // ----------------------------------------
  // Line assertions
  // ----------------------------------------
  a_idle_after_rst: assert property (@(posedge clk_i) disable iff (rst_i) $fell(rst_i) |-> st_line && dev_line)
    else $error("line not idle after reset");
  a_st_start_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_pos_r != 12'h000 && st_pos_r < 12'(BIT)) |-> !st_line)
    else $error("station start bit too short");
  a_st_stop_high: assert property (@(posedge clk_i) disable iff (rst_i) st_pos_r >= 12'(10 * BIT) |-> st_line)
    else $error("station stop bit low");
  a_st_bit_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_pos_r != 12'h000 && st_pos_r % 12'(BIT) != 12'h000) |-> $stable(st_line))
    else $error("station line moved inside a bit");
  a_dev_start_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (dev_pos_r != 12'h000 && dev_pos_r < 12'(BIT)) |-> !dev_line)
    else $error("device start bit too short");
  a_dev_bit_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (dev_pos_r != 12'h000 && dev_pos_r % 12'(BIT) != 12'h000) |-> $stable(dev_line))
    else $error("device line moved inside a bit");
  a_st_low_whole: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_line) |-> (st_low_r != 12'h000 && st_low_r % 12'(BIT) == 12'h000))
    else $error("station low run not whole bits");
  a_dev_low_whole: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(dev_line) |-> (dev_low_r != 12'h000 && dev_low_r % 12'(BIT) == 12'h000))
    else $error("device low run not whole bits");
endmodule : ump_link_props

// ### ump_pkg.sv
// Types shared by both ends of the serial link
package ump_pkg;
  typedef enum logic [1:0] {
    UMP_TX_IDLE = 2'b01,
    UMP_TX_SEND = 2'b10
  } ump_tx_state_t;
  typedef enum logic [2:0] {
    UMP_RX_IDLE = 3'b001,
    UMP_RX_HUNT = 3'b010,
    UMP_RX_RECV = 3'b100
  } ump_rx_state_t;
endpackage : ump_pkg

// ### ump_station.sv
// Station end: queues framed bytes onto the line and returns received frames
`timescale 1ns/1ns
`include "ump_defines.svh"
module ump_station #(
  parameter logic [7:0] TICK_DIV = 8'h00,
  parameter int DEPTH = 8
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Transmit words: bit 8 set marks an address byte
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [8:0] tx_data_i,
  // Received frames
  output logic rx_valid_o,
  output logic [8:0] rx_data_o,
  output logic rx_frame_err_o,
  // Serial link
  ump_link_if.st link
);
  logic [7:0] bcnt_r;
  wire tick = (bcnt_r == TICK_DIV);
  wire [4:0] ovs = `UMP_OVS_NORM;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcnt_r <= '0;
    end else if (ce_i) begin
      bcnt_r <= tick ? 8'h00 : bcnt_r + 8'h01;
    end
  end
  // ----------------------------------------
  // Transmit queue and shifter
  // ----------------------------------------
  ump_pkg::ump_tx_state_t tx_st_r;
  logic [10:0] tsh_r;
  logic [3:0] tcnt_r;
  logic [4:0] tsub_r;
  logic q_valid;
  logic [8:0] q_data;
  wire q_take = (tx_st_r == ump_pkg::UMP_TX_IDLE) & q_valid;
  wire tbit_end = (tx_st_r == ump_pkg::UMP_TX_SEND) & tick & (tsub_r == ovs - 5'h01);
  ump_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_txq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_data_i),
    .out_valid_o(q_valid),
    .out_ready_i(tx_st_r == ump_pkg::UMP_TX_IDLE),
    .out_data_o(q_data)
  );
  assign link.st_line = tsh_r[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_r <= ump_pkg::UMP_TX_IDLE;
      tsh_r <= `UMP_IDLE_FRAME;
      tcnt_r <= '0;
      tsub_r <= '0;
    end else if (ce_i) begin
      case (tx_st_r)
        ump_pkg::UMP_TX_IDLE: begin
          if (q_take) begin
            tsh_r <= {1'b1, q_data, 1'b0};
            tcnt_r <= `UMP_NB9;
            tsub_r <= '0;
            tx_st_r <= ump_pkg::UMP_TX_SEND;
          end
        end
        ump_pkg::UMP_TX_SEND: begin
          if (tbit_end) begin
            tsub_r <= '0;
            tsh_r <= {1'b1, tsh_r[10:1]};
            if (tcnt_r == 4'h0) begin
              tx_st_r <= ump_pkg::UMP_TX_IDLE;
            end else begin
              tcnt_r <= tcnt_r - 4'h1;
            end
          end else if (tick) begin
            tsub_r <= tsub_r + 5'h01;
          end
        end
        default: tx_st_r <= ump_pkg::UMP_TX_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  ump_pkg::ump_rx_state_t rx_st_r;
  logic [9:0] rsh_r;
  logic [3:0] rcnt_r;
  logic [4:0] rsub_r;
  logic rv_r;
  wire rline = link.dev_line;
  wire rbit_end = (rx_st_r == ump_pkg::UMP_RX_RECV) & tick & (rsub_r == ovs - 5'h01);
  assign rx_valid_o = rv_r;
  assign rx_data_o = rsh_r[8:0];
  assign rx_frame_err_o = ~rsh_r[9];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_r <= ump_pkg::UMP_RX_IDLE;
      rsh_r <= '1;
      rcnt_r <= '0;
      rsub_r <= '0;
      rv_r <= 1'b0;
    end else if (ce_i) begin
      rv_r <= 1'b0;
      case (rx_st_r)
        ump_pkg::UMP_RX_IDLE: begin
          if (tick & ~rline) begin
            rsub_r <= 5'h01;
            rx_st_r <= ump_pkg::UMP_RX_HUNT;
          end
        end
        ump_pkg::UMP_RX_HUNT: begin
          if (tick) begin
            if (rsub_r == {1'b0, ovs[4:1]} - 5'h01) begin
              rsub_r <= '0;
              rcnt_r <= '0;
              rx_st_r <= rline ? ump_pkg::UMP_RX_IDLE : ump_pkg::UMP_RX_RECV;
            end else begin
              rsub_r <= rsub_r + 5'h01;
            end
          end
        end
        ump_pkg::UMP_RX_RECV: begin
          if (rbit_end) begin
            rsub_r <= '0;
            rsh_r[rcnt_r] <= rline;
            if (rcnt_r == `UMP_NB9 - 4'h1) begin
              rv_r <= 1'b1;
              rx_st_r <= ump_pkg::UMP_RX_IDLE;
            end else begin
              rcnt_r <= rcnt_r + 4'h1;
            end
          end else if (tick) begin
            rsub_r <= rsub_r + 5'h01;
          end
        end
        default: rx_st_r <= ump_pkg::UMP_RX_IDLE;
      endcase
    end
  end
endmodule : ump_station
